// ### design/servo_io_state_monitor.sv
// Overview of operation
// R1: Gain accepts 0.0000..1.0000, resets to 1.0000.
// R2: Gain of zero switches feed-forward off.
// R3: Origin-defined readout: 0 undefined, 1 defined.
// R4: Input readouts use conditioned levels, not pins.
// R5: Output readouts taken before timer and inversion.
// R6: Pause readout: 0 normal, 1 paused.
// R7: Origin-limit readout: 1 near origin detected.
// R8: Return-done: finished and command still at origin.
// R9: Return-start readout: 1 while request asserted.
// R10: Integrator-disable readout: 1 integral control off.
// R11: In-position: completed and target position held.
// R12: Manual-step readout: 0 decelerate, 1 accelerate.
// R13: Count every edge of both feedback phases.
// R14: Writing zero clears the edge counter.
// R15: Proximity A readout: 1 nearing final target.
// R16: Proximity B readout independent, same encoding.
// R17: Normal readout: 0 alarm or warning, 1 normal.
// R18: Reads never change state; only zero write clears.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module servo_io_state_monitor
	import servo_monitor_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Wishbone classic slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic [31:0]                 wb_dat_o,
	output logic                        wb_ack_o,
	// Conditioned control inputs, after polarity and debounce
	input  wire logic                   pause_input,
	input  wire logic                   origin_limit_input,
	input  wire logic                   origin_return_start_input,
	input  wire logic                   integrator_disable_input,
	input  wire logic                   manualStepInput,
	// Internal output sources, before stabilization and inversion
	input  wire logic                   origin_defined_output,
	input  wire logic                   originReturnFinished,
	input  wire logic                   commandAtOrigin,
	input  wire logic                   positioningComplete,
	input  wire logic                   targetHeld,
	input  wire logic                   proximity_a_output,
	input  wire logic                   proximity_b_output,
	input  wire logic                   alarmPresent,
	input  wire logic                   warningPresent,
	// Feedback phases driven out of the unit
	input  wire logic                   feedbackPhaseA,
	input  wire logic                   feedbackPhaseB,
	// Control loop side
	output logic [GAIN_WIDTH-1:0]       feedforward_gain,
	output logic                        feedforwardEnable,
	output logic [OUT_WIDTH-1:0]        outputState,
	// Interrupt
	output logic                        irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic                   request;
	logic                   writeStrobe;
	logic                   hitGain;
	logic                   hitCount;
	logic                   hitStatus;
	logic                   hitMask;
	logic [31:0]            laneMask;
	logic [31:0]            writeBits;

	assign request     = wb_cyc_i & wb_stb_i;
	// Writes land at the edge where the master samples ack.
	assign writeStrobe = request & wb_we_i & wb_ack_o;
	assign hitGain     = wb_adr_i == GAIN_OFFSET;
	assign hitCount    = wb_adr_i == EDGE_COUNT_OFFSET;
	assign hitStatus   = wb_adr_i == IRQ_STATUS_OFFSET;
	assign hitMask     = wb_adr_i == IRQ_MASK_OFFSET;
	assign laneMask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign writeBits   = wb_dat_i & laneMask;

	// ------------------------------------------------------------
	// Feed-forward gain
	// ------------------------------------------------------------
	logic [31:0]            gainMerged;
	logic                   gainInRange;

	assign gainMerged  = ({18'h00000, feedforward_gain} & ~laneMask) | writeBits;
	// Out-of-range values are dropped so the loop never sees a gain above unity.
	assign gainInRange = gainMerged <= {18'h00000, GAIN_MAX};                       // see R1

	always_ff @(posedge clk)
	begin
		if (rst)
			feedforward_gain <= GAIN_RESET;                                          // see R1
		else if (writeStrobe & hitGain & gainInRange)
			feedforward_gain <= gainMerged[GAIN_WIDTH-1:0];
	end

	assign feedforwardEnable = feedforward_gain != GAIN_OFF;                        // see R2

	// ------------------------------------------------------------
	// Input and output state capture
	// ------------------------------------------------------------
	logic [IN_WIDTH-1:0]    inputState;
	logic [IN_WIDTH-1:0]    next_inputState;
	logic [OUT_WIDTH-1:0]   next_outputState;

	// Inputs arrive already conditioned; the pin level is never seen here.
	assign next_inputState[IN_PAUSE]        = pause_input;                          // see R4 see R6
	assign next_inputState[IN_ORIGIN_LIMIT] = origin_limit_input;                   // see R7
	assign next_inputState[IN_RETURN_START] = origin_return_start_input;            // see R9
	assign next_inputState[IN_INTEG_OFF]    = integrator_disable_input;             // see R10
	assign next_inputState[IN_MANUAL_STEP]  = manualStepInput;                      // see R12

	// Outputs are formed ahead of any stabilization timer or inversion.
	assign next_outputState[OUT_ORIGIN_DEFINED] = origin_defined_output;            // see R3 see R5
	assign next_outputState[OUT_RETURN_DONE]    = originReturnFinished & commandAtOrigin; // see R8
	assign next_outputState[OUT_IN_POSITION]    = positioningComplete & targetHeld; // see R11
	assign next_outputState[OUT_PROXIMITY_A]    = proximity_a_output;               // see R15
	assign next_outputState[OUT_PROXIMITY_B]    = proximity_b_output;               // see R16
	assign next_outputState[OUT_NORMAL]         = ~(alarmPresent | warningPresent); // see R17

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			inputState  <= '0;
			outputState <= '0;
		end
		else
		begin
			inputState  <= next_inputState;
			outputState <= next_outputState;
		end
	end

	// ------------------------------------------------------------
	// Feedback edge counter
	// ------------------------------------------------------------
	logic [COUNT_WIDTH-1:0] edgeCount;
	logic                   countWrapped;
	logic                   countClear;

	// Only a write whose enabled lanes are all zero clears; other writes are ignored.
	assign countClear = writeStrobe & hitCount & (wb_sel_i != 4'h0) & (writeBits == 32'h00000000); // see R14

	feedback_edge_counter #(
		.WIDTH   (COUNT_WIDTH)
	) edgeCounter (
		.clk     (clk),
		.rst     (rst),
		.phaseA  (feedbackPhaseA),
		.phaseB  (feedbackPhaseB),
		.clear   (countClear),
		.count   (edgeCount),
		.wrapped (countWrapped)
	);

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [IRQ_WIDTH-1:0]   irqStatus;
	logic [IRQ_WIDTH-1:0]   irqMask;
	logic [IRQ_WIDTH-1:0]   irqEvent;
	logic [IRQ_WIDTH-1:0]   irqClear;

	assign irqEvent[IRQ_COUNT_WRAP]  = countWrapped;
	assign irqEvent[IRQ_ALARM]       = outputState[OUT_NORMAL] & ~next_outputState[OUT_NORMAL];
	assign irqEvent[IRQ_IN_POSITION] = ~outputState[OUT_IN_POSITION] & next_outputState[OUT_IN_POSITION];
	assign irqEvent[IRQ_RETURN_DONE] = ~outputState[OUT_RETURN_DONE] & next_outputState[OUT_RETURN_DONE];
	assign irqClear = (writeStrobe & hitStatus) ? writeBits[IRQ_WIDTH-1:0] : '0;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irqStatus <= '0;
			irqMask   <= IRQ_MASK_RESET;
		end
		else
		begin
			// A new event in the clearing cycle stays set.
			irqStatus <= (irqStatus & ~irqClear) | irqEvent;
			if (writeStrobe & hitMask)
				irqMask <= (irqMask & ~laneMask[IRQ_WIDTH-1:0]) | writeBits[IRQ_WIDTH-1:0];
		end
	end

	assign irq = |(irqStatus & irqMask);

	// ------------------------------------------------------------
	// Read path and acknowledge
	// ------------------------------------------------------------
	logic [31:0]            readWord;

	// Pure selection: a read loads only wb_ack_o and wb_dat_o and touches no other state in the block.
	assign readWord =
		hitGain                              ? {18'h00000, feedforward_gain} :
		(wb_adr_i == INPUT_STATE_OFFSET)     ? {27'h0000000, inputState} :
		(wb_adr_i == OUTPUT_STATE_OFFSET)    ? {26'h0000000, outputState} :
		hitCount                             ? edgeCount :
		hitStatus                            ? {28'h0000000, irqStatus} :
		hitMask                              ? {28'h0000000, irqMask} :
		32'h00000000;                                                           // see R18

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= request & ~wb_ack_o;
			wb_dat_o <= (request & ~wb_ack_o & ~wb_we_i) ? readWord : 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// ### design/servo_monitor_pkg.sv
package servo_monitor_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [7:0] GAIN_OFFSET        = 8'h00;
	localparam logic [7:0] INPUT_STATE_OFFSET = 8'h04;
	localparam logic [7:0] OUTPUT_STATE_OFFSET = 8'h08;
	localparam logic [7:0] EDGE_COUNT_OFFSET  = 8'h0c;
	localparam logic [7:0] IRQ_STATUS_OFFSET  = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFFSET    = 8'h14;

	// ------------------------------------------------------------
	// Feed-forward gain, in steps of 0.0001
	// ------------------------------------------------------------
	localparam int         GAIN_WIDTH = 14;
	localparam logic [13:0] GAIN_MAX   = 14'h2710;
	localparam logic [13:0] GAIN_RESET = 14'h2710;
	localparam logic [13:0] GAIN_OFF   = 14'h0000;

	// ------------------------------------------------------------
	// Input state word bit positions
	// ------------------------------------------------------------
	localparam int IN_PAUSE        = 0;
	localparam int IN_ORIGIN_LIMIT = 1;
	localparam int IN_RETURN_START = 2;
	localparam int IN_INTEG_OFF    = 3;
	localparam int IN_MANUAL_STEP  = 4;
	localparam int IN_WIDTH        = 5;

	// ------------------------------------------------------------
	// Output state word bit positions
	// ------------------------------------------------------------
	localparam int OUT_ORIGIN_DEFINED = 0;
	localparam int OUT_RETURN_DONE    = 1;
	localparam int OUT_IN_POSITION    = 2;
	localparam int OUT_PROXIMITY_A    = 3;
	localparam int OUT_PROXIMITY_B    = 4;
	localparam int OUT_NORMAL         = 5;
	localparam int OUT_WIDTH          = 6;

	// ------------------------------------------------------------
	// Interrupt status and mask bit positions
	// ------------------------------------------------------------
	localparam int IRQ_COUNT_WRAP   = 0;
	localparam int IRQ_ALARM        = 1;
	localparam int IRQ_IN_POSITION  = 2;
	localparam int IRQ_RETURN_DONE  = 3;
	localparam int IRQ_WIDTH        = 4;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	localparam int COUNT_WIDTH = 32;

endpackage

// ### design/feedback_edge_counter.sv
`timescale 1ns/1ns
`default_nettype none

module feedback_edge_counter
	import servo_monitor_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Feedback phases as driven out of the unit
	input  wire logic             phaseA,
	input  wire logic             phaseB,
	// Control
	input  wire logic             clear,
	// Result
	output logic [WIDTH-1:0]      count,
	output logic                  wrapped
);

	logic             lastA;
	logic             lastB;
	logic [1:0]       step;
	logic [WIDTH:0]   sum;

	// Both phases count on rise and fall, so one clock may add two.
	assign step = {1'b0, phaseA ^ lastA} + {1'b0, phaseB ^ lastB};
	assign sum  = {1'b0, count} + {{(WIDTH-1){1'b0}}, step};

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lastA   <= 1'b0;
			lastB   <= 1'b0;
			count   <= '0;
			wrapped <= 1'b0;
		end
		else
		begin
			lastA   <= phaseA;
			lastB   <= phaseB;
			// A clear restarts from zero; edges of that same cycle are dropped.
			count   <= clear ? '0 : sum[WIDTH-1:0];                  // see R13 see R14
			wrapped <= ~clear & sum[WIDTH];
		end
	end

endmodule

`default_nettype wire

// ### bench/servo_monitor_sva.sv
`timescale 1ns/1ns
`default_nettype none
module servo_monitor_sva
	import servo_monitor_pkg::*;
(
	// Clock, reset and bus
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	// State sources
	input wire logic                  origin_defined_output,
	input wire logic                  originReturnFinished,
	input wire logic                  commandAtOrigin,
	input wire logic                  positioningComplete,
	input wire logic                  targetHeld,
	input wire logic                  proximity_a_output,
	input wire logic                  proximity_b_output,
	input wire logic                  alarmPresent,
	input wire logic                  warningPresent,
	// Loop side
	input wire logic [GAIN_WIDTH-1:0] feedforward_gain,
	input wire logic                  feedforwardEnable,
	input wire logic [OUT_WIDTH-1:0]  outputState,
	input wire logic                  irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
	gain_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == GAIN_OFFSET
		|-> wb_dat_o == {18'h0, feedforward_gain}) else $error("gain readback");
	gain_range_a: assert property (feedforward_gain <= GAIN_MAX) else $error("gain range");
	gain_reset_a: assert property ($past(rst) |-> feedforward_gain == GAIN_RESET) else $error("gain reset");
	ff_off_a: assert property (feedforwardEnable == (feedforward_gain != GAIN_OFF)) else $error("ff enable");
	origin_def_a: assert property (!$past(rst) |-> outputState[OUT_ORIGIN_DEFINED] == $past(origin_defined_output))
		else $error("origin defined");
	ret_done_a: assert property (!$past(rst) |-> outputState[OUT_RETURN_DONE] ==
		($past(originReturnFinished) && $past(commandAtOrigin))) else $error("return done");
	in_pos_a: assert property (!$past(rst) |-> outputState[OUT_IN_POSITION] ==
		($past(positioningComplete) && $past(targetHeld))) else $error("in position");
	prox_pair_a: assert property (!$past(rst) |-> outputState[4:3] ==
		{$past(proximity_b_output), $past(proximity_a_output)}) else $error("proximity");
	normal_out_a: assert property (!$past(rst) |-> outputState[OUT_NORMAL] ==
		!($past(alarmPresent) || $past(warningPresent))) else $error("normal");
	cover property (wb_ack_o && wb_we_i);
	cover property (wb_ack_o && !wb_we_i);
	cover property ($rose(irq));
endmodule
bind servo_io_state_monitor servo_monitor_sva chk_u (.*);
`default_nettype wire

// ### bench/host_terminal.sv
`timescale 1ns/1ns
`default_nettype none
module host_terminal (
	// Clock
	input  wire logic        clk,
	// Wishbone master
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      datW,
	input  wire logic [31:0] datR,
	input  wire logic        ack
);
	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		datW = 32'h0;
	end
	// Released address and data lines carry the inverse, so a stale address or word never looks valid.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		datW <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a;
		datW <= ~d;
	endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import servo_monitor_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [13:0] pins = 14'h0;
	logic        phA = 1'b0;
	logic        phB = 1'b0;
	logic        cyc, stb, we, ack, ffEn, irq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] datW, datR, q;
	logic [13:0] gain;
	logic [5:0]  outSt;
	logic [15:0] lfsr = 16'hd898;
	int          errors = 0;
	int          num_checks = 0;
	int          gainM = 10000;
	int          cntM = 0;
	int          gv[4] = '{0, 10001, 4660, 10000};
	always #5 clk = ~clk;
	servo_io_state_monitor dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
		.pause_input(pins[0]), .origin_limit_input(pins[1]), .origin_return_start_input(pins[2]),
		.integrator_disable_input(pins[3]), .manualStepInput(pins[4]), .origin_defined_output(pins[5]),
		.originReturnFinished(pins[6]), .commandAtOrigin(pins[7]), .positioningComplete(pins[8]),
		.targetHeld(pins[9]), .proximity_a_output(pins[10]), .proximity_b_output(pins[11]),
		.alarmPresent(pins[12]), .warningPresent(pins[13]), .feedbackPhaseA(phA), .feedbackPhaseB(phB),
		.feedforward_gain(gain), .feedforwardEnable(ffEn), .outputState(outSt), .irq(irq));
	host_terminal host_u (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.datW(datW), .datR(datR), .ack(ack));
	// ------------------------------------------------------------
	// Model and helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] outWord(input logic [13:0] p);
		return {26'h0, ~(p[12] | p[13]), p[11], p[10], p[8] & p[9], p[6] & p[7], p[5]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		host_u.xfer(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(a, 1'b1, d, q);
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(GAIN_OFFSET, 32'h2710);
		foreach (gv[i])
		begin
			wr(GAIN_OFFSET, gv[i]);
			if (gv[i] <= 10000)
				gainM = gv[i];
			rd(GAIN_OFFSET, gainM);
			chk({31'h0, ffEn}, {31'h0, gainM != 0});
		end
		repeat (20)
		begin
			lfsr = lfsrNext(lfsr);
			@(posedge clk);
			pins <= lfsr[13:0];
			// The new pin word is still pending here, so the expectation comes from the generator.
			rd(INPUT_STATE_OFFSET, {27'h0, lfsr[4:0]});
			rd(OUTPUT_STATE_OFFSET, outWord(lfsr[13:0]));
		end
		wr(INPUT_STATE_OFFSET, 32'hffffffff);
		rd(INPUT_STATE_OFFSET, {27'h0, pins[4:0]});
		rd(8'h18, 32'h0);
		wr(EDGE_COUNT_OFFSET, 32'h0);
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk);
			phA <= ~phA;
			if (i % 2 == 1)
				phB <= ~phB;
			cntM += 1 + i % 2;
		end
		repeat (2) @(posedge clk);
		rd(EDGE_COUNT_OFFSET, cntM);
		wr(EDGE_COUNT_OFFSET, 32'h5);
		rd(EDGE_COUNT_OFFSET, cntM);
		wr(EDGE_COUNT_OFFSET, 32'h0);
		rd(EDGE_COUNT_OFFSET, 32'h0);
		@(posedge clk);
		pins <= 14'h0;
		repeat (3) @(posedge clk);
		wr(IRQ_STATUS_OFFSET, 32'hf);
		rd(IRQ_STATUS_OFFSET, 32'h0);
		pins[12] <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(IRQ_STATUS_OFFSET, 32'h2);
		wr(IRQ_MASK_OFFSET, 32'h2);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(IRQ_STATUS_OFFSET, 32'h2);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		results();
	end
	// The whole sequence needs well under a thousand cycles.
	initial
	begin
		#50000;
		errors++;
		results();
	end
endmodule
`default_nettype wire
